// file: shared/idu_pkg.sv
// idu_pkg: word indices, field positions and reset values for the
// upper identification words (93..255).
// assumes: one 100 MHz clock, word index supplied by the data-port logic.
package idu_pkg;
   localparam int unsigned idu_word_w = 16;
   localparam logic [7:0] idu_hw_reset_result_idx = 8'h5d;
   localparam logic [7:0] idu_zero_bc_idx = 8'h7e;
   localparam logic [7:0] idu_media_notify_idx = 8'h7f;
   localparam logic [7:0] idu_security_idx = 8'h80;
   localparam logic [7:0] idu_vendor_first_idx = 8'h81;
   localparam logic [7:0] idu_vendor_last_idx = 8'h9f;
   localparam logic [7:0] idu_integrity_idx = 8'hff;
   localparam logic [7:0] idu_last_idx = 8'hff;
   // device number method codes
   localparam logic [1:0] idu_dn_jumper = 2'h1;
   localparam logic [1:0] idu_dn_csel = 2'h2;
   localparam logic [1:0] idu_dn_other = 2'h3;
   // media notification support codes
   localparam logic [1:0] idu_mn_none = 2'h0;
   localparam logic [1:0] idu_mn_supported = 2'h1;
   // fixed field positions of the reset result word
   localparam int unsigned idu_rr_zero_bit = 15;
   localparam int unsigned idu_rr_one_bit = 14;
   localparam int unsigned idu_rr_cable_bit = 13;
   localparam int unsigned idu_rr_d1_valid_bit = 8;
   localparam int unsigned idu_rr_d0_valid_bit = 0;
   // reset values
   localparam logic [12:0] idu_rr_low_rst = 13'h0000;
   localparam logic [7:0] idu_sum_rst = 8'h00;
   localparam logic [7:0] idu_idx_rst = 8'h00;
   localparam logic [15:0] idu_word_rst = 16'h0000;
   // sync stages for pins
   localparam int unsigned idu_sync_len = 3;

   // hardware reset observations, sampled on pins
   typedef struct packed {
      logic is_device1;     // device number is 1
      logic cable_high;     // cable id line sampled high
      logic pdiag_seen;     // pdiag asserted (device 1 drove / device 0 saw)
      logic dasp_seen;      // device 0 saw dasp from device 1
      logic diag_pass;      // device 0 self diagnostics passed
      logic resp_d1_sel;    // device 0 answers while device 1 selected
      logic [1:0] dn_method;
   } idu_hw_obs_s;

   // fixed and variable status from the rest of the device
   typedef struct packed {
      logic [15:0] zero_bc_word;
      logic [1:0] media_notify;
      logic sec_max_level;
      logic [5:0] sec_flags;   // 5 erase..0 supported
      logic [7:0] signature;
   } idu_status_s;

   // builds the reset-result low part from the observations for one device role
   function automatic logic [12:0] idu_rr_low(input idu_hw_obs_s o);
      logic [12:0] r;
      r = 13'h0000;
      if (o.is_device1) begin
         r[11] = o.pdiag_seen;
         r[10:9] = o.dn_method;
         r[8] = 1'b1;
      end else begin
         r[6] = o.resp_d1_sel;
         r[5] = o.dasp_seen;
         r[4] = o.pdiag_seen;
         r[3] = o.diag_pass;
         r[2:1] = o.dn_method;
         r[0] = 1'b1;
      end
      return r;
   endfunction

   // adds both bytes of a word into a running byte sum
   function automatic logic [7:0] idu_byte_sum(input logic [7:0] acc,
                                               input logic [15:0] w);
      return 8'(acc + w[7:0] + w[15:8]);
   endfunction
endpackage

// file: rtl/idu_pin_sync.sv
// idu_pin_sync: three-stage pin synchroniser with agreement filter.
// assumes: pin is asynchronous to clk; output moves only when stages
// two and three agree, so a glitch one clock long never gets through.
`timescale 1ns/1ps
module idu_pin_sync
   import idu_pkg::*;
#(
   parameter int unsigned width = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [width-1:0] pin,
   output logic [width-1:0] level
);
   logic [width-1:0] s1_q;
   logic [width-1:0] s2_q;
   logic [width-1:0] s3_q;

   // shift chain; stage one is only read by stage two
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // per-bit agreement filter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         level <= '0;
      end else begin
         for (int i = 0; i < int'(width); i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// file: rtl/idu_upper_words.sv
// idu_upper_words: serves identification words 93..255 to the data port.
// assumes: the data-port logic presents a word index with rd_strobe once
// per word in ascending order; hw_reset_active is high while a hardware
// reset executes; observation pins are asynchronous.
//
// Functional notes
// - reset result bits 12..0 change only while hardware reset runs
// - reset result bit 15 reads zero, bit 14 reads one
// - bit 13 reflects sampled cable identification level
// - device 0 returns bits 12..8 as zero
// - device 1 returns bits 7..0 as zero
// - device 1 bit 11 shows own pdiag assertion; bit 12 reserved
// - device 1 bits 10..9 encode device number method
// - device 1 bit 8 always one
// - device 0 bit 6 shows answering while device 1 selected
// - device 0 bit 5 shows dasp seen from device 1
// - device 0 bit 4 shows pdiag seen
// - device 0 bit 3 shows diagnostics pass
// - device 0 bits 2..1 encode device number method; bit 7 reserved
// - device 0 bit 0 always one
// - word 127 bits 1..0 give media notification support, rest zero
// - security word bit 8 gives security level
// - security word bits 5..0 are the security flags
// - word 126 is a fixed zero byte count behaviour value
// - reserved words read as zero
// - fixed words constant except during hardware reset or on media change
// - variable words return current value at every read
`timescale 1ns/1ps
module idu_upper_words
   import idu_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hw_reset_active,
   input wire logic media_changed,
   input wire logic [6:0] obs_pins,
   input wire logic [1:0] obs_dn_method,
   input wire idu_status_s status_in,
   input wire logic rec_start,
   input wire logic rd_strobe,
   input wire logic [7:0] rd_index,
   input wire logic [15:0] lower_word,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic [15:0] rr_word,
   output logic seq_error
);
   // obs_pins: 6 dev1,5 cable,4 pdiag,3 dasp,2 diag,1 resp,0 unused
   logic [6:0] pin_lvl;
   idu_hw_obs_s obs;
   logic [13:0] rr_low_q; // cable level above the 13 reset-result bits
   idu_status_s fixed_q;
   logic [7:0] sum_q;
   logic [7:0] exp_idx_q;
   logic [15:0] word_d;
   logic [15:0] rr_full;
   logic [15:0] integ_d;

   idu_pin_sync #(
      .width(7)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .pin(obs_pins),
      .level(pin_lvl)
   );

   // pin levels gathered; method code is driven by same-clock logic
   always_comb begin
      obs.is_device1 = pin_lvl[6];
      obs.cable_high = pin_lvl[5];
      obs.pdiag_seen = pin_lvl[4];
      obs.dasp_seen = pin_lvl[3];
      obs.diag_pass = pin_lvl[2];
      obs.resp_d1_sel = pin_lvl[1];
      obs.dn_method = obs_dn_method;
   end

   // reset-only capture
   // the low thirteen bits track observations only during hardware reset,
   // so what software sees is the last value sampled in that reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rr_low_q <= {1'b0, idu_rr_low_rst};
      end else if (hw_reset_active) begin
         rr_low_q <= {obs.cable_high, idu_rr_low(obs)};
      end
   end

   // fixed marker bits
   // bit 13 is the cable level captured with the rest
   always_comb begin
      rr_full = {1'b0, 1'b1, rr_low_q};
   end

   // fixed words latched
   // fixed words only reload on reset or media change, so a host sees a
   // stable record even if the inputs wander meanwhile
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fixed_q <= '0;
      end else if (hw_reset_active || media_changed) begin
         fixed_q <= status_in;
      end
   end

   // word selection for the upper part of the record
   always_comb begin
      word_d = idu_word_rst;
      if (rd_index < idu_hw_reset_result_idx) begin
         word_d = lower_word;
      end else begin
         unique case (rd_index)
            idu_hw_reset_result_idx: word_d = rr_full;
            idu_zero_bc_idx: word_d = fixed_q.zero_bc_word;
            idu_media_notify_idx: word_d = {14'h0000, fixed_q.media_notify};
            idu_security_idx: word_d = {7'h00, status_in.sec_max_level,
                                        2'h0, status_in.sec_flags};
            idu_integrity_idx: word_d = integ_d;
            default: word_d = idu_word_rst;
         endcase
      end
   end

   // checksum completes sum
   // signature counted first, then checksum is the two's complement
   always_comb begin
      logic [7:0] part;
      part = 8'(sum_q + fixed_q.signature);
      integ_d = {8'(8'h00 - part), fixed_q.signature};
   end

   // ascending word order
   // running sum and expected index; an out-of-order read is flagged and
   // the sum restarts at the next record, trading recovery for simplicity
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sum_q <= idu_sum_rst;
         exp_idx_q <= idu_idx_rst;
         seq_error <= 1'b0;
      end else if (rec_start) begin
         sum_q <= idu_sum_rst;
         exp_idx_q <= idu_idx_rst;
         seq_error <= 1'b0;
      end else if (rd_strobe) begin
         sum_q <= idu_byte_sum(sum_q, word_d);
         exp_idx_q <= 8'(exp_idx_q + 8'h01);
         if (rd_index != exp_idx_q) begin
            seq_error <= 1'b1;
         end
      end
   end

   // registered answer, one cycle after the strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data <= idu_word_rst;
         rd_valid <= 1'b0;
         rr_word <= 16'h4000;
      end else begin
         rd_valid <= rd_strobe;
         rr_word <= rr_full;
         if (rd_strobe) begin
            rd_data <= word_d;
         end
      end
   end
endmodule

// file: bench/idu_upper_words_checker.sv
// idu_upper_words_checker: port-level checks on the upper id words
// assumes: bound to idu_upper_words, single clock, nrst async low
`timescale 1ns/1ps
module idu_upper_words_checker
   import idu_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hw_reset_active,
   input wire logic media_changed,
   input wire logic [6:0] obs_pins,
   input wire logic [1:0] obs_dn_method,
   input wire idu_status_s status_in,
   input wire logic rec_start,
   input wire logic rd_strobe,
   input wire logic [7:0] rd_index,
   input wire logic [15:0] lower_word,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic [15:0] rr_word,
   input wire logic seq_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // one strobed read of a given word
   sequence s_rd(logic [7:0] i);
      rd_strobe && rd_index == i;
   endsequence
   // two quiet edges first, since rr_word trails the capture by one
   property p_rr_hold;
      !hw_reset_active && !$past(hw_reset_active) &&
      !$past(hw_reset_active, 2) |-> $stable(rr_word[12:0]);
   endproperty
   property p_rr_top;
      rr_word[15:14] == 2'b01;
   endproperty
   property p_dev0;
      rr_word[0] |-> rr_word[12:7] == 6'h00;
   endproperty
   property p_dev1;
      rr_word[8] |-> rr_word[7:0] == 8'h00 && !rr_word[12];
   endproperty
   property p_answer;
      rd_strobe |=> rd_valid;
   endproperty
   property p_quiet;
      !rd_strobe |=> !rd_valid;
   endproperty
   property p_rsvd;
      rd_strobe && rd_index inside {[8'h5e:8'h7d], [8'h81:8'hfe]}
         |=> rd_data == 16'h0000;
   endproperty
   property p_media;
      s_rd(idu_media_notify_idx) |=> rd_data[15:2] == 14'h0000;
   endproperty
   property p_sec;
      s_rd(idu_security_idx) |=> rd_data == {7'h00,
         $past(status_in.sec_max_level), 2'b00, $past(status_in.sec_flags)};
   endproperty
   property p_restart;
      rec_start |=> !seq_error;
   endproperty
   a_rr_hold: assert property (p_rr_hold)
      else $error("reset result moved outside hw reset");
   a_rr_top: assert property (p_rr_top)
      else $error("reset result top bits wrong");
   a_dev0: assert property (p_dev0)
      else $error("device 0 upper byte not clear");
   a_dev1: assert property (p_dev1)
      else $error("device 1 lower byte not clear");
   a_answer: assert property (p_answer)
      else $error("no answer after strobe");
   a_quiet: assert property (p_quiet)
      else $error("answer without strobe");
   a_rsvd: assert property (p_rsvd)
      else $error("reserved word not zero");
   a_media: assert property (p_media)
      else $error("media word high bits set");
   a_sec: assert property (p_sec)
      else $error("security word wrong");
   a_restart: assert property (p_restart)
      else $error("order error not cleared");
endmodule
bind idu_upper_words idu_upper_words_checker chk (.*);

// file: bench/idu_host_model.sv
// idu_host_model: host adapter side, reads records word by word
// assumes: bench calls its tasks at falling edges
`timescale 1ns/1ps
module idu_host_model
   import idu_pkg::*;
(
   input wire logic clk,
   output logic rec_start,
   output logic rd_strobe,
   output logic [7:0] rd_index,
   output logic [15:0] lower_word,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid
);
   logic [15:0] words [256];
   logic [7:0] last;
   initial begin
      rec_start = 0;
      rd_strobe = 0;
      rd_index = 0;
      lower_word = 0;
   end
   // answer belongs to the index strobed one edge earlier
   always @(posedge clk) begin
      if (rd_strobe) last <= rd_index;
      if (rd_valid) words[last] <= rd_data;
   end
   task read_record(input bit slow);
      int i;
      rec_start = 1;
      @(negedge clk);
      rec_start = 0;
      for (i = 0; i < 256; i++) begin
         rd_strobe = 1;
         rd_index = i[7:0];
         // words above 92 are not ours: keep the line toggling
         lower_word = i < 93 ? {i[7:0], ~i[7:0]} : ~lower_word;
         @(negedge clk);
         if (slow) begin
            rd_strobe = 0;
            @(negedge clk);
         end
      end
      rd_strobe = 0;
      repeat (3) @(negedge clk);
   endtask
   task read_one(input logic [7:0] i);
      rd_strobe = 1;
      rd_index = i;
      @(negedge clk);
      rd_strobe = 0;
      @(negedge clk);
   endtask
endmodule

// file: bench/identify_data_upper_words_bench.sv
// identify_data_upper_words_bench: reset result, record and order tests
// assumes: host model drives the read port, bench drives the rest
`timescale 1ns/1ps
module identify_data_upper_words_bench;
   import idu_pkg::*;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
   logic clk = 0, nrst = 0, hw = 0, mc = 0;
   logic [6:0] pins = 0;
   logic [1:0] dn = 1;
   idu_status_s st = {16'h00a5, 2'b01, 1'b1, 6'h2b, 8'h5c};
   logic rec_start, rd_strobe, rd_valid, seq_error;
   logic [7:0] rd_index, sum;
   logic [15:0] lower_word, rd_data, rr_word, acc;
   logic [15:0] rr_exp = 16'h4000; // last reset result built from the rules
   int fail_count = 0, samples_checked = 0;
   always #5 clk = ~clk;
   idu_upper_words dut (.clk(clk), .nrst(nrst), .hw_reset_active(hw),
      .media_changed(mc), .obs_pins(pins), .obs_dn_method(dn),
      .status_in(st), .rec_start(rec_start), .rd_strobe(rd_strobe),
      .rd_index(rd_index), .lower_word(lower_word), .rd_data(rd_data),
      .rd_valid(rd_valid), .rr_word(rr_word), .seq_error(seq_error));
   idu_host_model h (.clk(clk), .rec_start(rec_start),
      .rd_strobe(rd_strobe), .rd_index(rd_index),
      .lower_word(lower_word), .rd_data(rd_data), .rd_valid(rd_valid));
   task results;
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // pins settle past the synchroniser before the reset window opens
   task t_reset_word;
      logic [15:0] e;
      logic [6:0] p;
      logic [1:0] m;
      logic a, b, d1;
      for (int i = 0; i < 6; i++) begin
         m = 2'(i % 3 + 1);
         d1 = i > 2;
         a = i[0];
         b = i[1];
         p = {d1, b, a, ~a, b, a ^ b, 1'b0};
         pins = p;
         dn = m;
         repeat (6) @(negedge clk);
         hw = 1;
         repeat (8) @(negedge clk);
         hw = 0;
         repeat (4) @(negedge clk);
         e = d1 ? {2'b01, b, 1'b0, a, m, 1'b1, 8'h00}
                : {2'b01, b, 6'h00, a ^ b, ~a, a, b, m, 1'b1};
         `CHK("rr", e, rr_word)
         pins = ~p;
         dn = ~m;
         repeat (8) @(negedge clk);
         `CHK("rr_hold", e, rr_word)
         rr_exp = e;
      end
   endtask
   task t_record(input bit slow, input logic [15:0] zb,
                 input logic [1:0] mn);
      h.read_record(slow);
      sum = 0;
      acc = 0;
      for (int k = 0; k < 256; k++) begin
         sum = 8'(sum + h.words[k][7:0] + h.words[k][15:8]);
         if (k > 93 && k < 255 && (k < 126 || k > 128)) acc |= h.words[k];
      end
      `CHK("sum", 8'h00, sum)
      `CHK("sig", st.signature, h.words[255][7:0])
      `CHK("w93", rr_exp, h.words[93])
      `CHK("rr_now", rr_exp, rr_word)
      `CHK("w126", zb, h.words[126])
      `CHK("w127", {14'h0, mn}, h.words[127])
      `CHK("w128", {7'h0, st.sec_max_level, 2'b0, st.sec_flags},
           h.words[128])
      `CHK("rsvd", 16'h0000, acc)
      `CHK("seq", 1'b0, seq_error)
   endtask
   initial begin
      repeat (10) @(negedge clk);
      nrst = 1;
      @(negedge clk);
      mc = 1;
      @(negedge clk);
      mc = 0;
      t_reset_word;
      t_record(0, 16'h00a5, 2'b01);
      // fixed words ignore edits until media change, security is live
      st = {16'h5a00, 2'b00, 1'b0, 6'h14, 8'h5c};
      t_record(1, 16'h00a5, 2'b01);
      mc = 1;
      @(negedge clk);
      mc = 0;
      t_record(0, 16'h5a00, 2'b00);
      h.read_one(8'h05);
      `CHK("seq_err", 1'b1, seq_error)
      // a fresh record must clear the order flag left by the stray read
      t_record(0, 16'h5a00, 2'b00);
      results;
   end
   // hang guard
   initial begin
      #200us;
      fail_count++;
      results;
   end
endmodule
